// [hw/gei_regs.vh]
// Register map, reset values and field positions of the edge event block
`ifndef GEI_REGS_VH
`define GEI_REGS_VH

`define GEI_OFF_BLOCK_UPPER 8'h08
`define GEI_OFF_BLOCK_LOWER 8'h09
`define GEI_OFF_SEL_15_12 8'h0A
`define GEI_OFF_SEL_7_4 8'h0B
`define GEI_OFF_SEL_11_8 8'h0C
`define GEI_OFF_SEL_3_0 8'h0D
`define GEI_OFF_SRC_UPPER 8'h0E
`define GEI_OFF_SRC_LOWER 8'h0F
`define GEI_OFF_EVT_UPPER 8'h10
`define GEI_OFF_EVT_LOWER 8'h11
`define GEI_OFF_LOOKUP_MODE 8'h20

`define GEI_RST_BLOCK 8'hFF
`define GEI_RST_SEL 8'h00
`define GEI_RST_SRC 8'h00
`define GEI_RST_EVT 8'h00
`define GEI_RST_LOOKUP_MODE 8'h00

`define GEI_LOOKUP_MODE_HI 5
`define GEI_LOOKUP_MODE_LO 4

`define GEI_SEL_NONE 2'h0
`define GEI_SEL_RISE 2'h1
`define GEI_SEL_FALL 2'h2
`define GEI_SEL_BOTH 2'h3

`define GEI_MODE_GPIO 2'h0
`define GEI_MODE_PIN14 2'h1
`define GEI_MODE_PIN15 2'h2

`define GEI_DEV_ADDR 7'h20

`endif

// [hw/gei_i2c_slave.v]
// Two-wire register port slave with pointer auto-increment
`timescale 1ns/1ps
`include "gei_regs.vh"
module gei_i2c_slave #(
  parameter [6:0] DEV_ADDR = `GEI_DEV_ADDR
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Link pins
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output reg sda_oe,
  // Register side
  output reg [7:0] reg_ptr,
  input wire [7:0] rd_data,
  output reg wr_stb,
  output reg [7:0] wr_addr,
  output reg [7:0] wr_data
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_ACK_A = 3'h2;
  localparam [2:0] ST_WRITE = 3'h3;
  localparam [2:0] ST_ACK_W = 3'h4;
  localparam [2:0] ST_READ = 3'h5;
  localparam [2:0] ST_MACK = 3'h6;

  reg [2:0] scl_s;
  reg [2:0] sda_s;
  reg scl_f;
  reg sda_f;
  reg scl_q;
  reg sda_q;
  reg [2:0] state_r;
  reg [3:0] bitcnt_r;
  reg [7:0] shreg_r;
  reg rnw_r;
  reg first_r;
  wire scl_rise;
  wire scl_fall;
  wire start_c;
  wire stop_c;

  assign sda_o = 1'b0;

  // Three-stage sampling, accept a level once stages two and three agree
  always @(posedge clk) begin
    if (sys_rst) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_s <= {scl_s[1:0], scl_i};
      sda_s <= {sda_s[1:0], sda_i};
      if (scl_s[1] == scl_s[2])
        scl_f <= scl_s[2];
      if (sda_s[1] == sda_s[2])
        sda_f <= sda_s[2];
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  assign scl_rise = scl_f & ~scl_q;
  assign scl_fall = ~scl_f & scl_q;
  assign start_c = scl_f & scl_q & sda_q & ~sda_f;
  assign stop_c = scl_f & scl_q & ~sda_q & sda_f;

  always @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      bitcnt_r <= 4'h0;
      shreg_r <= 8'h00;
      rnw_r <= 1'b0;
      first_r <= 1'b0;
      sda_oe <= 1'b0;
      reg_ptr <= 8'h00;
      wr_stb <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (start_c) begin
        state_r <= ST_ADDR;
        bitcnt_r <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_c) begin
        state_r <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        case (state_r)
          ST_ADDR, ST_WRITE: begin
            shreg_r <= {shreg_r[6:0], sda_f};
            bitcnt_r <= bitcnt_r + 4'h1;
          end
          ST_READ: bitcnt_r <= bitcnt_r + 4'h1;
          ST_MACK: begin
            if (sda_f)
              state_r <= ST_IDLE;
          end
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state_r)
          ST_ADDR: begin
            if (bitcnt_r == 4'h8) begin
              if (shreg_r[7:1] == DEV_ADDR) begin
                rnw_r <= shreg_r[0];
                sda_oe <= 1'b1;
                state_r <= ST_ACK_A;
              end else begin
                state_r <= ST_IDLE;
              end
            end
          end
          ST_ACK_A: begin
            bitcnt_r <= 4'h0;
            if (rnw_r) begin
              shreg_r <= rd_data;
              sda_oe <= ~rd_data[7];
              state_r <= ST_READ;
            end else begin
              sda_oe <= 1'b0;
              first_r <= 1'b1;
              state_r <= ST_WRITE;
            end
          end
          ST_WRITE: begin
            if (bitcnt_r == 4'h8) begin
              sda_oe <= 1'b1;
              state_r <= ST_ACK_W;
              if (first_r) begin
                reg_ptr <= shreg_r;
                first_r <= 1'b0;
              end else begin
                wr_stb <= 1'b1;
                wr_addr <= reg_ptr;
                wr_data <= shreg_r;
                reg_ptr <= reg_ptr + 8'h01;
              end
            end
          end
          ST_ACK_W: begin
            sda_oe <= 1'b0;
            bitcnt_r <= 4'h0;
            state_r <= ST_WRITE;
          end
          ST_READ: begin
            if (bitcnt_r == 4'h8) begin
              sda_oe <= 1'b0;
              reg_ptr <= reg_ptr + 8'h01;
              state_r <= ST_MACK;
            end else begin
              shreg_r <= {shreg_r[6:0], 1'b0};
              sda_oe <= ~shreg_r[6];
            end
          end
          ST_MACK: begin
            bitcnt_r <= 4'h0;
            shreg_r <= rd_data;
            sda_oe <= ~rd_data[7];
            state_r <= ST_READ;
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end
endmodule

// [hw/gei_irq_status.v]
// Edge event detection, interrupt source status and upper-nibble lookup
`timescale 1ns/1ps
`include "gei_regs.vh"
module gei_irq_status #(
  parameter NPINS = 16,
  parameter [6:0] DEV_ADDR = `GEI_DEV_ADDR
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Two-wire register port
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe,
  // GPIO pin levels
  input wire [NPINS-1:0] gpio_in,
  // Lookup tables for the upper nibble
  input wire [3:0] lut_pin14,
  input wire [7:0] lut_pin15,
  // Lookup outputs for pins 15:12
  output reg [3:0] lut_drive,
  output reg [3:0] lut_oe,
  // Interrupt pin, open drain
  output wire irq_out_n_o,
  output wire irq_out_n_oe
);
  reg [NPINS-1:0] pin_s1_r;
  reg [NPINS-1:0] pin_s2_r;
  reg [NPINS-1:0] pin_s3_r;
  reg [NPINS-1:0] pin_f_r;
  reg pin_valid_r;
  reg [7:0] irq_block_upper_bank;
  reg [7:0] irq_block_lower_bank;
  reg [7:0] sel_15_12_r;
  reg [7:0] sel_7_4_r;
  reg [7:0] sel_11_8_r;
  reg [7:0] sel_3_0_r;
  reg [7:0] irq_source_upper_bank;
  reg [7:0] irq_source_lower_bank;
  reg [7:0] edge_event_upper_bank;
  reg [7:0] edge_event_lower_bank;
  reg [7:0] lookup_mode_upper_bank;
  reg [7:0] rd_data;
  reg [3:0] lut_drive_nxt;
  reg [3:0] lut_oe_nxt;
  wire [7:0] reg_ptr;
  wire wr_stb;
  wire [7:0] wr_addr;
  wire [7:0] wr_data;
  wire [2*NPINS-1:0] edge_select;
  wire [NPINS-1:0] edge_hit;
  wire [NPINS-1:0] irq_block;
  wire [NPINS-1:0] src_all;
  wire [NPINS-1:0] evt_all;
  wire [NPINS-1:0] clr_w;
  wire [NPINS-1:0] src_nxt;
  wire [NPINS-1:0] evt_nxt;
  wire [1:0] lookup_mode_upper_nibble;

  function wr_hit;
    input stb;
    input [7:0] addr;
    input [7:0] off;
    begin
      wr_hit = stb & (addr == off);
    end
  endfunction

  function edge_match;
    input [1:0] sel;
    input prev;
    input cur;
    begin
      case (sel)
        `GEI_SEL_RISE: edge_match = ~prev & cur;
        `GEI_SEL_FALL: edge_match = prev & ~cur;
        `GEI_SEL_BOTH: edge_match = prev ^ cur;
        default: edge_match = 1'b0;
      endcase
    end
  endfunction

  gei_i2c_slave #(
    .DEV_ADDR(DEV_ADDR)
  ) u_port (
    .clk(clk),
    .sys_rst(sys_rst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .reg_ptr(reg_ptr),
    .rd_data(rd_data),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  // Pin sampling; pin_valid_r masks edges only in the first cycle, while pin_f_r loads pin_s3_r, still zero from reset
  always @(posedge clk) begin
    if (sys_rst) begin
      pin_s1_r <= {NPINS{1'b0}};
      pin_s2_r <= {NPINS{1'b0}};
      pin_s3_r <= {NPINS{1'b0}};
      pin_f_r <= {NPINS{1'b0}};
      pin_valid_r <= 1'b0;
    end else begin
      pin_s1_r <= gpio_in;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_valid_r <= 1'b1;
      if (!pin_valid_r)
        pin_f_r <= pin_s3_r;
      else
        pin_f_r <= (pin_s2_r & pin_s3_r) | (pin_f_r & (pin_s2_r ^ pin_s3_r));
    end
  end

  assign edge_select = {sel_15_12_r, sel_11_8_r, sel_7_4_r, sel_3_0_r};
  assign irq_block = {irq_block_upper_bank, irq_block_lower_bank};
  assign src_all = {irq_source_upper_bank, irq_source_lower_bank};
  assign evt_all = {edge_event_upper_bank, edge_event_lower_bank};

  // Stable-level change once stages agree, filtered by edge select
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi = gi + 1) begin : g_pin
      wire agreed_cur;
      assign agreed_cur = (pin_s2_r[gi] == pin_s3_r[gi]) ? pin_s3_r[gi] : pin_f_r[gi];
      assign edge_hit[gi] = pin_valid_r
        & edge_match(edge_select[2*gi+1:2*gi], pin_f_r[gi], agreed_cur);
    end
  endgenerate

  // Either register's write-one clears both bits of the pin
  assign clr_w[15:8] = (wr_hit(wr_stb, wr_addr, `GEI_OFF_SRC_UPPER) ? wr_data : 8'h00)
    | (wr_hit(wr_stb, wr_addr, `GEI_OFF_EVT_UPPER) ? wr_data : 8'h00);
  assign clr_w[7:0] = (wr_hit(wr_stb, wr_addr, `GEI_OFF_SRC_LOWER) ? wr_data : 8'h00)
    | (wr_hit(wr_stb, wr_addr, `GEI_OFF_EVT_LOWER) ? wr_data : 8'h00);

  // A new edge in the clearing cycle wins over the clear
  assign evt_nxt = (evt_all & ~clr_w) | edge_hit;
  assign src_nxt = (src_all & ~clr_w) | (edge_hit & ~irq_block);

  always @(posedge clk) begin
    if (sys_rst) begin
      irq_block_upper_bank <= `GEI_RST_BLOCK;
      irq_block_lower_bank <= `GEI_RST_BLOCK;
      sel_15_12_r <= `GEI_RST_SEL;
      sel_7_4_r <= `GEI_RST_SEL;
      sel_11_8_r <= `GEI_RST_SEL;
      sel_3_0_r <= `GEI_RST_SEL;
      irq_source_upper_bank <= `GEI_RST_SRC;
      irq_source_lower_bank <= `GEI_RST_SRC;
      edge_event_upper_bank <= `GEI_RST_EVT;
      edge_event_lower_bank <= `GEI_RST_EVT;
      lookup_mode_upper_bank <= `GEI_RST_LOOKUP_MODE;
    end else begin
      if (wr_hit(wr_stb, wr_addr, `GEI_OFF_BLOCK_UPPER))
        irq_block_upper_bank <= wr_data;
      if (wr_hit(wr_stb, wr_addr, `GEI_OFF_BLOCK_LOWER))
        irq_block_lower_bank <= wr_data;
      if (wr_hit(wr_stb, wr_addr, `GEI_OFF_SEL_15_12))
        sel_15_12_r <= wr_data;
      if (wr_hit(wr_stb, wr_addr, `GEI_OFF_SEL_7_4))
        sel_7_4_r <= wr_data;
      if (wr_hit(wr_stb, wr_addr, `GEI_OFF_SEL_11_8))
        sel_11_8_r <= wr_data;
      if (wr_hit(wr_stb, wr_addr, `GEI_OFF_SEL_3_0))
        sel_3_0_r <= wr_data;
      // Stored as written; reserved bits are the host's to keep at zero
      if (wr_hit(wr_stb, wr_addr, `GEI_OFF_LOOKUP_MODE))
        lookup_mode_upper_bank <= wr_data;
      irq_source_upper_bank <= src_nxt[15:8];
      irq_source_lower_bank <= src_nxt[7:0];
      edge_event_upper_bank <= evt_nxt[15:8];
      edge_event_lower_bank <= evt_nxt[7:0];
    end
  end

  // Read data for the register port; unmapped reads as zero
  always @* begin
    case (reg_ptr)
      `GEI_OFF_BLOCK_UPPER: rd_data = irq_block_upper_bank;
      `GEI_OFF_BLOCK_LOWER: rd_data = irq_block_lower_bank;
      `GEI_OFF_SEL_15_12: rd_data = sel_15_12_r;
      `GEI_OFF_SEL_7_4: rd_data = sel_7_4_r;
      `GEI_OFF_SEL_11_8: rd_data = sel_11_8_r;
      `GEI_OFF_SEL_3_0: rd_data = sel_3_0_r;
      `GEI_OFF_SRC_UPPER: rd_data = irq_source_upper_bank;
      `GEI_OFF_SRC_LOWER: rd_data = irq_source_lower_bank;
      `GEI_OFF_EVT_UPPER: rd_data = edge_event_upper_bank;
      `GEI_OFF_EVT_LOWER: rd_data = edge_event_lower_bank;
      `GEI_OFF_LOOKUP_MODE: rd_data = lookup_mode_upper_bank;
      default: rd_data = 8'h00;
    endcase
  end

  assign lookup_mode_upper_nibble =
    lookup_mode_upper_bank[`GEI_LOOKUP_MODE_HI:`GEI_LOOKUP_MODE_LO];

  // Lookup decode of the upper nibble
  always @* begin
    lut_drive_nxt = 4'h0;
    lut_oe_nxt = 4'h0;
    case (lookup_mode_upper_nibble)
      `GEI_MODE_PIN14: begin
        lut_oe_nxt[2] = 1'b1;
        lut_drive_nxt[2] = lut_pin14[pin_f_r[13:12]];
      end
      `GEI_MODE_PIN15: begin
        lut_oe_nxt[3] = 1'b1;
        lut_drive_nxt[3] = lut_pin15[pin_f_r[14:12]];
      end
      default: begin
        lut_drive_nxt = 4'h0;
        lut_oe_nxt = 4'h0;
      end
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      lut_drive <= 4'h0;
      lut_oe <= 4'h0;
    end else begin
      lut_drive <= lut_drive_nxt;
      lut_oe <= lut_oe_nxt;
    end
  end

  // Open drain: pulled low while any source bit is pending
  assign irq_out_n_o = 1'b0;
  assign irq_out_n_oe = |src_all;
endmodule

// [dv/gei_irq_status_properties.sv]
// Port-level assertions of the edge event block
`timescale 1ns/1ps
module gei_irq_status_properties #(
  parameter NPINS = 16
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Observed ports
  input wire scl_i,
  input wire sda_i,
  input wire sda_o,
  input wire sda_oe,
  input wire [NPINS-1:0] gpio_in,
  input wire [3:0] lut_pin14,
  input wire [7:0] lut_pin15,
  input wire [3:0] lut_drive,
  input wire [3:0] lut_oe,
  input wire irq_out_n_o,
  input wire irq_out_n_oe
);
  reg [3:0] gpio_age_r = 4'hF;
  reg [3:0] scl_age_r = 4'hF;
  reg [NPINS-1:0] gpio_q_r;
  reg scl_q_r;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Cycles since the last pin or clock-line change
  always @(posedge clk) begin
    gpio_q_r <= gpio_in;
    scl_q_r <= scl_i;
    gpio_age_r <= (gpio_in != gpio_q_r) ? 4'h0 : gpio_age_r + {3'h0, gpio_age_r != 4'hF};
    scl_age_r <= (scl_i != scl_q_r) ? 4'h0 : scl_age_r + {3'h0, scl_age_r != 4'hF};
  end
  a_drive_const_zero: assert property (irq_out_n_o == 1'b0 && sda_o == 1'b0)
    else $error("open drain drive value not zero");
  a_irq_after_reset: assert property (disable iff (1'b0) sys_rst |=> !irq_out_n_oe)
    else $error("interrupt pulled after reset");
  a_lut_after_reset: assert property (disable iff (1'b0) sys_rst |=> lut_oe == 4'h0)
    else $error("lookup drive after reset");
  a_lut_oe_legal: assert property (lut_oe[1:0] == 2'h0 && lut_oe != 4'hC)
    else $error("illegal lookup enable");
  a_pin14_decode: assert property (
    ($stable(gpio_in) && $stable(lut_pin14)) [*6] ##0 lut_oe[2]
    |-> lut_drive[2] == lut_pin14[gpio_in[13:12]])
    else $error("pin14 decode wrong");
  a_pin15_decode: assert property (
    ($stable(gpio_in) && $stable(lut_pin15)) [*6] ##0 lut_oe[3]
    |-> lut_drive[3] == lut_pin15[gpio_in[14:12]])
    else $error("pin15 decode wrong");
  a_irq_rise_cause: assert property ($rose(irq_out_n_oe) |-> gpio_age_r < 4'h8)
    else $error("interrupt without pin edge");
  a_irq_fall_cause: assert property ($fell(irq_out_n_oe)
    |-> scl_age_r < 4'hC || $past(sys_rst))
    else $error("interrupt released without host write");
  c_irq_raised: cover property ($rose(irq_out_n_oe));
  c_pin14_mode: cover property (lut_oe[2]);
  c_pin15_mode: cover property (lut_oe[3]);
endmodule
bind gei_irq_status gei_irq_status_properties #(.NPINS(NPINS)) u_props (.clk(clk),
  .sys_rst(sys_rst), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .gpio_in(gpio_in), .lut_pin14(lut_pin14), .lut_pin15(lut_pin15), .lut_drive(lut_drive),
  .lut_oe(lut_oe), .irq_out_n_o(irq_out_n_o), .irq_out_n_oe(irq_out_n_oe));

// [dv/gei_host_model.sv]
// Two-wire host model making register accesses
`timescale 1ns/1ps
module gei_host_model #(
  parameter [6:0] DEV_ADDR = 7'h20
) (
  // Link pins
  output reg scl,
  output reg sda_pull,
  input wire sda_wire
);
  localparam real Q = 31.25;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task start;
    begin
      #Q sda_pull = 1'b0;
      #Q scl = 1'b1;
      #Q sda_pull = 1'b1;
      #Q scl = 1'b0;
    end
  endtask
  // Clock stands high after stop
  task stop;
    begin
      #Q sda_pull = 1'b1;
      #Q scl = 1'b1;
      #Q sda_pull = 1'b0;
      #Q;
    end
  endtask
  task xbit(input b, output r);
    begin
      #Q sda_pull = ~b;
      #Q scl = 1'b1;
      #Q r = sda_wire;
      #Q scl = 1'b0;
    end
  endtask
  // Nine bits; last is the ninth bit sent, ack the device pulling it
  task xbyte(input [7:0] d, input last, output [7:0] r, output ack);
    integer i;
    reg t;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        xbit(d[i], t);
        r[i] = t;
      end
      xbit(last, t);
      ack = ~t;
    end
  endtask
  task wr_reg(input [7:0] off, input [7:0] d, output ok);
    reg [7:0] r;
    reg a1, a2, a3;
    begin
      start;
      xbyte({DEV_ADDR, 1'b0}, 1'b1, r, a1);
      xbyte(off, 1'b1, r, a2);
      xbyte(d, 1'b1, r, a3);
      stop;
      ok = a1 & a2 & a3;
    end
  endtask
  task rd_reg(input [7:0] off, output [7:0] d, output ok);
    reg [7:0] r;
    reg a1, a2, a3, t;
    begin
      start;
      xbyte({DEV_ADDR, 1'b0}, 1'b1, r, a1);
      xbyte(off, 1'b1, r, a2);
      start;
      xbyte({DEV_ADDR, 1'b1}, 1'b1, r, a3);
      xbyte(8'hFF, 1'b1, d, t);
      stop;
      ok = a1 & a2 & a3;
    end
  endtask
endmodule

// [dv/tb.sv]
// Self-checking bench of the edge event block
`timescale 1ns/1ps
module tb;
  reg clk;
  reg sys_rst;
  reg [15:0] gpio_in;
  reg [3:0] lut_pin14;
  reg [7:0] lut_pin15;
  wire scl, sda_pull, sda_o, sda_oe, sda_wire, irq_out_n_o, irq_out_n_oe;
  wire [3:0] lut_drive, lut_oe;
  integer n_errors, num_checks, cyc, s, e;
  reg [7:0] d;
  reg [31:0] rnd;
  reg ok, hit;
  assign sda_wire = ~(sda_pull | sda_oe);
  gei_irq_status u_gei_irq_status (.clk(clk), .sys_rst(sys_rst), .scl_i(scl),
    .sda_i(sda_wire), .sda_o(sda_o), .sda_oe(sda_oe), .gpio_in(gpio_in),
    .lut_pin14(lut_pin14), .lut_pin15(lut_pin15), .lut_drive(lut_drive), .lut_oe(lut_oe),
    .irq_out_n_o(irq_out_n_o), .irq_out_n_oe(irq_out_n_oe));
  gei_host_model u_gei_host_model (.scl(scl), .sda_pull(sda_pull), .sda_wire(sda_wire));
  task chk(input [7:0] got, input [7:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] off, input [7:0] val);
    begin
      u_gei_host_model.wr_reg(off, val, ok);
      chk({7'h0, ok}, 8'h01);
    end
  endtask
  task rchk(input [7:0] off, input [7:0] exp);
    begin
      u_gei_host_model.rd_reg(off, d, ok);
      chk({7'h0, ok}, 8'h01);
      chk(d, exp);
    end
  endtask
  function hit_of(input [1:0] sel, input lvl);
    hit_of = lvl ? sel[0] : sel[1];
  endfunction
  function [3:0] oe_of(input [1:0] m);
    oe_of = (m == 2'h1) ? 4'h4 : (m == 2'h2) ? 4'h8 : 4'h0;
  endfunction
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    cyc = 0;
    forever begin
      @(posedge clk);
      cyc = cyc + 1;
      if (cyc == 80000) begin
        n_errors = n_errors + 1;
        tally_and_finish;
      end
    end
  end
  initial begin
    n_errors = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    gpio_in = 16'h0000;
    lut_pin14 = 4'h0;
    lut_pin15 = 8'h00;
    rnd = $urandom(32'hFE725D89);
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    rnd = $urandom;
    gpio_in = rnd[15:0];
    repeat (4) @(negedge clk);
    for (s = 8; s < 18; s = s + 1) rchk(s[7:0], (s < 10) ? 8'hFF : 8'h00);
    rchk(8'h20, 8'h00);
    rchk(8'h30, 8'h00);
    wr(8'h09, 8'hFE);
    for (s = 0; s < 4; s = s + 1) begin
      wr(8'h0D, s[7:0]);
      for (e = 0; e < 2; e = e + 1) begin
        @(negedge clk);
        gpio_in[0] = ~gpio_in[0];
        repeat (8) @(negedge clk);
        hit = hit_of(s[1:0], gpio_in[0]);
        rchk(8'h11, {7'h0, hit});
        rchk(8'h0F, {7'h0, hit});
        chk({7'h0, irq_out_n_oe}, {7'h0, hit});
        wr((e == 0) ? 8'h0F : 8'h11, 8'h01);
        rchk(8'h0F, 8'h00);
        rchk(8'h11, 8'h00);
        chk({7'h0, irq_out_n_oe}, 8'h00);
      end
    end
    wr(8'h0C, 8'h03);
    @(negedge clk);
    gpio_in[8] = ~gpio_in[8];
    repeat (8) @(negedge clk);
    rchk(8'h10, 8'h01);
    rchk(8'h0E, 8'h00);
    chk({7'h0, irq_out_n_oe}, 8'h00);
    wr(8'h10, 8'h01);
    rchk(8'h10, 8'h00);
    for (s = 0; s < 8; s = s + 1) begin
      @(negedge clk);
      rnd = $urandom;
      lut_pin14 = rnd[3:0];
      lut_pin15 = rnd[11:4];
      gpio_in[14:12] = rnd[14:12];
      wr(8'h20, {2'b00, s[1:0], 4'h0});
      repeat (8) @(negedge clk);
      chk({4'h0, lut_oe}, {4'h0, oe_of(s[1:0])});
      chk({4'h0, lut_drive & ~oe_of(s[1:0])}, 8'h00);
      if (s[1:0] == 2'h1) chk({7'h0, lut_drive[2]}, {7'h0, lut_pin14[gpio_in[13:12]]});
      if (s[1:0] == 2'h2) chk({7'h0, lut_drive[3]}, {7'h0, lut_pin15[gpio_in[14:12]]});
      rchk(8'h20, {2'b00, s[1:0], 4'h0});
    end
    tally_and_finish;
  end
endmodule
